/* File: hdl/slts_dwell.sv */
/*
  Dwell down-counter giving a one-cycle expiry strobe.
  Assumes run and reload come from logic on pclk.
*/
`timescale 1ns/1ps
module slts_dwell #(
  parameter int W = 32
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         run,
  input  wire logic         reload,
  input  wire logic [W-1:0] dwell_cyc,
  output logic              expire
);
  logic [W-1:0] cnt_q, cnt_d, top;

  // Zero dwell treated as one cycle
  assign top    = (dwell_cyc == '0) ? '0 : dwell_cyc - W'(1);
  assign expire = run & ~reload & (cnt_q == '0);

  // Reload on each step, count down while running
  always_comb begin
    if (!run || reload || expire) cnt_d = top;
    else cnt_d = cnt_q - W'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end

  dwell_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    expire && dwell_cyc > W'(1) |=> !expire) else $error("dwell expired twice");
endmodule : slts_dwell

/* File: hdl/slts_pkg.sv */
/*
  Shared constants and types of the sweep/list trigger sequencer.
  Assumes a 100 MHz pclk and an APB master with 32-bit data.
*/
// Behaviour
// - One stepper serves sweep and list operation
// - External triggers only on the trigger pin
// - Late steps are delayed, never dropped
// - Growing delay flags overrun, excessive halts
// - Reset command returns to start value
// - Auto mode is the reset default
// - Auto mode starts at once on enable
// - Timed modes step on dwell expiry
// - Clearing enable stops generation
// - Single mode loads start, awaits trigger
// - Single trigger runs one start-to-end cycle
// - Single mode holds at end value
// - Retrace returns to start after cycle
// - Single triggered by command or pin
// - Step mode one step per trigger, wraps
// - Step requests carry up or down
// - Out-of-range step requests are ignored
// - List and sweep enables exclude each other
package slts_pkg;

  localparam int IDX_W   = 16;
  localparam int DWELL_W = 32;
  localparam int PEND_W  = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_START  = 8'h08;
  localparam logic [7:0] OFS_STOP   = 8'h0c;
  localparam logic [7:0] OFS_DWELL  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Command bit positions (write-only pulses)
  localparam int CMD_EXEC  = 0;
  localparam int CMD_UP    = 1;
  localparam int CMD_DOWN  = 2;
  localparam int CMD_RESET = 3;

  // Status bit positions
  localparam int ST_ACTIVE = 0;
  localparam int ST_ARMED  = 1;
  localparam int ST_OVR    = 2;
  localparam int ST_ERR    = 3;
  localparam int ST_IDX    = 16;

  typedef enum logic [1:0] {
    TM_AUTO,
    TM_SINGLE,
    TM_STEP
  } slts_mode_t;

  // Control register layout, top bit down to bit 0
  typedef struct packed {
    logic       retrace;
    logic       ext_src;
    slts_mode_t mode;
    logic       list_en;
    logic       sweep_en;
  } slts_ctrl_t;

  localparam slts_ctrl_t CTRL_RST = '{retrace: 1'b0, ext_src: 1'b0, mode: TM_AUTO,
                                      list_en: 1'b0, sweep_en: 1'b0};
  localparam logic [DWELL_W-1:0] DWELL_RST = 32'h0000_03e8;
  localparam logic [IDX_W-1:0]   STOP_RST  = 16'h000f;

  // Settling time of one applied step, and the pending-step overrun limit
  localparam int CLK_NS     = 10;
  localparam int SETTLE_NS  = 40;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int OVR_LIMIT  = 8;

endpackage : slts_pkg

/* File: hdl/slts_sequencer.sv */
/*
  Sweep/list trigger sequencer with APB register slave.
  Assumes an APB master on pclk; trig_pin is asynchronous.
*/
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module slts_sequencer #(
  parameter int SETTLE = slts_pkg::SETTLE_CYC,
  parameter int LIMIT  = slts_pkg::OVR_LIMIT
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        trig_pin,
  output logic      [slts_pkg::IDX_W-1:0]  step_index,
  output logic                             step_strobe,
  output logic                             gen_active,
  output logic                             overrun,
  output logic                             gen_error
);
  import slts_pkg::*;

  function automatic logic mapped(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_CMD || a == OFS_START || a == OFS_STOP ||
           a == OFS_DWELL || a == OFS_STATUS;
  endfunction : mapped

  slts_ctrl_t          ctrl_q, ctrl_d;
  logic [IDX_W-1:0]    start_q, start_d, stop_q, stop_d, cur_q, cur_d;
  logic [DWELL_W-1:0]  dwell_q, dwell_d;
  logic [PEND_W-1:0]   pend_q, pend_d;
  logic [7:0]          settle_q, settle_d;
  logic                armed_q, armed_d, ovr_q, ovr_d, err_q, err_d;
  logic                en_q, en_d, strobe_q, strobe_d;
  logic [31:0]         prdata_q, prdata_d;
  logic                wr, rd_setup, cmd_exec, cmd_up, cmd_down, cmd_rst;
  logic                en, trig_evt, trig, expire, timed_run, req, apply;
  logic                at_end, ascend, stepped, halt, ovr_clr, err_clr;

  // Control word width, taken from the packed layout
  localparam int CTRL_W = $bits(slts_ctrl_t);

  slts_trig_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .trig_pin (trig_pin),
    .trig_evt (trig_evt)
  );

  slts_dwell #(.W(DWELL_W)) u_dwell (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (timed_run),
    .reload    (stepped | cmd_rst),
    .dwell_cyc (dwell_q),
    .expire    (expire)
  );

  // APB decode, zero wait states
  assign wr       = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & ~mapped(paddr);
  assign prdata   = prdata_q;

  // Command pulses
  assign cmd_exec = wr && paddr == OFS_CMD && pwdata[CMD_EXEC];
  assign cmd_up   = wr && paddr == OFS_CMD && pwdata[CMD_UP];
  assign cmd_down = wr && paddr == OFS_CMD && pwdata[CMD_DOWN];
  assign cmd_rst  = wr && paddr == OFS_CMD && pwdata[CMD_RESET];

  // Trigger source and stepping requests, shared by sweep and list
  assign en        = ctrl_q.sweep_en | ctrl_q.list_en;
  assign trig      = ctrl_q.ext_src ? trig_evt : cmd_exec;
  assign timed_run = en_q & (ctrl_q.mode == TM_AUTO ||
                     (ctrl_q.mode == TM_SINGLE && armed_q));
  assign req       = en_q & ~cmd_rst & (expire ||
                     (ctrl_q.mode == TM_STEP && trig));
  assign apply     = en_q & (pend_q != '0) & (settle_q == '0);
  assign ascend    = stop_q >= start_q;
  assign at_end    = cur_q == stop_q;
  assign halt      = req && pend_q == PEND_W'(LIMIT - 1);

  // Write-one-to-clear strobes of the sticky flags
  assign ovr_clr   = wr && paddr == OFS_STATUS && pwdata[ST_OVR];
  assign err_clr   = wr && paddr == OFS_STATUS && pwdata[ST_ERR];

  // Output and sequencing state next values
  always_comb begin
    cur_d    = cur_q;
    armed_d  = armed_q;
    pend_d   = pend_q;
    settle_d = (settle_q != '0) ? settle_q - 8'd1 : settle_q;
    strobe_d = 1'b0;
    stepped  = 1'b0;
    en_d     = en;
    ovr_d    = ovr_q;
    err_d    = err_q;
    if (en && !en_q) begin
      cur_d   = start_q;
      armed_d = 1'b0;
      pend_d  = '0;
    end else if (!en_q) begin
      armed_d = 1'b0;
      pend_d  = '0;
    end else if (cmd_rst) begin
      cur_d   = start_q;
      armed_d = 1'b0;
      pend_d  = '0;
    end else begin
      // Queue instead of dropping late steps
      pend_d = pend_q + PEND_W'(req) - PEND_W'(apply);
      if (apply) begin
        stepped  = 1'b1;
        strobe_d = 1'b1;
        settle_d = 8'(SETTLE);
        if (at_end && ctrl_q.mode == TM_SINGLE) begin
          armed_d = 1'b0;
          pend_d  = '0;
          if (ctrl_q.retrace) cur_d = start_q;
        end else if (at_end) cur_d = start_q;
        else cur_d = ascend ? cur_q + IDX_W'(1) : cur_q - IDX_W'(1);
      end else if (ctrl_q.mode == TM_STEP && (cmd_up ^ cmd_down) && pend_q == '0) begin
        // Direct up/down, ignored past the range
        if (cmd_up && cur_q != stop_q) begin
          cur_d    = ascend ? cur_q + IDX_W'(1) : cur_q - IDX_W'(1);
          strobe_d = 1'b1;
        end else if (cmd_down && cur_q != start_q) begin
          cur_d    = ascend ? cur_q - IDX_W'(1) : cur_q + IDX_W'(1);
          strobe_d = 1'b1;
        end
      end
      if (ctrl_q.mode == TM_SINGLE && !armed_q && trig) begin
        armed_d = 1'b1;
        cur_d   = start_q;
        pend_d  = '0;
      end
    end
    // Clears first, so a same-cycle set wins
    if (ovr_clr) ovr_d = 1'b0;
    if (err_clr) err_d = 1'b0;
    if (req && pend_q != '0) ovr_d = 1'b1;
    if (halt) begin
      err_d  = 1'b1;
      en_d   = 1'b0;
      pend_d = '0;
    end
  end

  // Register file next values; halt clear beats a same-cycle enable write
  always_comb begin
    ctrl_d   = ctrl_q;
    start_d  = start_q;
    stop_d   = stop_q;
    dwell_d  = dwell_q;
    prdata_d = prdata_q;
    if (wr && paddr == OFS_CTRL) begin
      ctrl_d = slts_ctrl_t'(pwdata[CTRL_W-1:0]);
      // Unused mode code falls back to auto
      if (!(ctrl_d.mode inside {TM_AUTO, TM_SINGLE, TM_STEP})) ctrl_d.mode = TM_AUTO;
      // List enable wins and switches the sweep off
      if (ctrl_d.list_en) ctrl_d.sweep_en = 1'b0;
    end
    if (halt) begin
      ctrl_d.sweep_en = 1'b0;
      ctrl_d.list_en  = 1'b0;
    end
    if (wr && paddr == OFS_START) start_d = pwdata[IDX_W-1:0];
    if (wr && paddr == OFS_STOP) stop_d = pwdata[IDX_W-1:0];
    if (wr && paddr == OFS_DWELL) dwell_d = pwdata;
    if (rd_setup) begin
      unique case (paddr)
        OFS_CTRL:   prdata_d = {26'h0, ctrl_q};
        OFS_START:  prdata_d = {16'h0, start_q};
        OFS_STOP:   prdata_d = {16'h0, stop_q};
        OFS_DWELL:  prdata_d = dwell_q;
        OFS_STATUS: prdata_d = {cur_q, 12'h0, err_q, ovr_q, armed_q, en_q};
        default:    prdata_d = 32'h0;
      endcase
    end
  end

  // Register every state group; ctrl, stop and dwell reset values from the package
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= CTRL_RST;
      start_q  <= '0;
      stop_q   <= STOP_RST;
      dwell_q  <= DWELL_RST;
      prdata_q <= '0;
      cur_q    <= '0;
      armed_q  <= 1'b0;
      pend_q   <= '0;
      settle_q <= '0;
      ovr_q    <= 1'b0;
      err_q    <= 1'b0;
      en_q     <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      start_q  <= start_d;
      stop_q   <= stop_d;
      dwell_q  <= dwell_d;
      prdata_q <= prdata_d;
      cur_q    <= cur_d;
      armed_q  <= armed_d;
      pend_q   <= pend_d;
      settle_q <= settle_d;
      ovr_q    <= ovr_d;
      err_q    <= err_d;
      en_q     <= en_d;
      strobe_q <= strobe_d;
    end
  end

  // Outputs straight from flip-flops
  assign step_index  = cur_q;
  assign step_strobe = strobe_q;
  assign gen_active  = en_q;
  assign overrun     = ovr_q;
  assign gen_error   = err_q;

  // Steps of the halt and enable behaviours
  sequence halt_seen_s;
    halt;
  endsequence

  sequence gen_stopped_s;
    !en_q && err_q;
  endsequence

  sequence enable_edge_s;
    en && !en_q;
  endsequence

  sequence start_loaded_s;
    cur_q == $past(start_q) && !armed_q;
  endsequence

  halt_stops_a: assert property (@(posedge pclk) disable iff (!presetn)
    halt_seen_s |=> gen_stopped_s) else $error("halt did not stop generation");

  enable_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    enable_edge_s |=> start_loaded_s) else $error("enable did not load start value");

  idle_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    !en_q |=> !armed_q && pend_q == '0) else $error("disabled sequencer kept state");

  range_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    en_q && ctrl_q.mode == TM_STEP && cmd_up && !cmd_down && !cmd_exec && !cmd_rst &&
    cur_q == stop_q && pend_q == '0 |=> cur_q == $past(cur_q))
    else $error("out-of-range step moved output");

  ovr_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    ovr_q && !ovr_clr |=> ovr_q) else $error("overrun flag lost");
endmodule : slts_sequencer

/* File: hdl/slts_trig_sync.sv */
/*
  Trigger pin synchroniser with rising-edge detect.
  Assumes an asynchronous trigger pulse wider than two pclk periods.
*/
`timescale 1ns/1ps
module slts_trig_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trig_pin,
  output logic      trig_evt
);
  logic meta_q, sync_q, last_q;
  logic meta_d, sync_d, last_d;

  // Two stages, then edge detect on the second only
  always_comb begin
    meta_d = trig_pin;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign trig_evt = sync_q & ~last_q;

  one_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig_evt |=> !trig_evt) else $error("trigger event longer than one cycle");
endmodule : slts_trig_sync

/* File: tb/slts_trig_src.sv */
/*
  External trigger source model driving the trigger pin.
  Assumes fire is a one-cycle request from the bench on pclk.
*/
`timescale 1ns/1ps
module slts_trig_src (
  input  wire logic pclk,
  input  wire logic fire,
  output logic      trig_pin
);
  logic [2:0] cnt_q = 3'h0;

  // Pulse four cycles wide, well over the synchroniser depth
  always_ff @(posedge pclk) begin
    if (fire) cnt_q <= 3'h4;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end

  // Single pin carries every external trigger
  assign trig_pin = (cnt_q != 3'h0);
endmodule : slts_trig_src

/* File: tb/sweep_list_trigger_sequencer_tb.sv */
/*
  Self-checking bench of the sweep/list sequencer over APB.
  Assumes the design asserts its own rules; bench drives on pclk.
*/
`timescale 1ns/1ps
module sweep_list_trigger_sequencer_tb;
  import slts_pkg::*;
  logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic             pwrite = 1'b0, fire = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0, prdata, rd;
  logic             pready, pslverr, trig_pin, step_strobe, gen_active, overrun, gen_error;
  logic [IDX_W-1:0] step_index;
  int               error_cnt = 0, num_checks = 0, strobes = 0;
  logic             perr;

  // Count step strobes as the design issues them
  always @(posedge pclk) if (step_strobe === 1'b1) strobes++;

  // 100 MHz clock
  always #5 pclk = ~pclk;

  slts_sequencer #(.SETTLE(20), .LIMIT(4)) slts_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_pin(trig_pin), .step_index(step_index), .step_strobe(step_strobe),
    .gen_active(gen_active), .overrun(overrun), .gen_error(gen_error));

  slts_trig_src slts_trig_src_i (.pclk(pclk), .fire(fire), .trig_pin(trig_pin));

  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task fail(input string m);
    error_cnt++;
    $display("mismatch at %0t: %s", $time, m);
    tally_and_finish();
  endtask : fail

  task chk(input logic ok, input string m);
    num_checks++;
    if (!ok) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  // APB transfer held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 50) fail("apb timeout");
  endtask : apb

  task wctrl(input logic rt, input logic ex, input slts_mode_t m, input logic le,
             input logic se);
    slts_ctrl_t c;
    c = '{rt, ex, m, le, se};
    apb(1'b1, OFS_CTRL, 32'(c));
  endtask : wctrl

  task cmd(input int b);
    apb(1'b1, OFS_CMD, 32'h1 << b);
  endtask : cmd

  task automatic wt_idx(input logic [IDX_W-1:0] v, input int b);
    int n;
    for (n = 0; n < b && step_index !== v; n++) @(negedge pclk);
    num_checks++;
    if (step_index !== v) fail("step index not reached");
  endtask : wt_idx

  // Flag waits: 0 active, 1 idle, 2 overrun, 3 error
  task automatic wt_sig(input int s, input int b);
    int n;
    logic ok;
    ok = 1'b0;
    for (n = 0; n < b && !ok; n++) begin
      @(negedge pclk);
      ok = (s == 0) ? gen_active === 1'b1 : (s == 1) ? gen_active === 1'b0 :
           (s == 2) ? overrun === 1'b1 : gen_error === 1'b1;
    end
    num_checks++;
    if (!ok) fail("flag not reached");
  endtask : wt_sig

  task t_reset;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd === 32'(CTRL_RST), "ctrl reset");
    chk(perr === 1'b0, "error on mapped read");
    apb(1'b0, OFS_DWELL, 32'h0);
    chk(rd === DWELL_RST, "dwell reset");
    apb(1'b0, OFS_STOP, 32'h0);
    chk(rd[IDX_W-1:0] === STOP_RST, "stop reset");
    apb(1'b0, 8'h3c, 32'h0);
    chk(perr === 1'b1, "no error on unmapped read");
    chk(gen_active === 1'b0, "idle after reset");
    $display("test reset done");
  endtask : t_reset

  task t_auto;
    apb(1'b1, OFS_START, 32'h2);
    apb(1'b1, OFS_STOP, 32'h5);
    apb(1'b1, OFS_DWELL, 32'd40);
    wctrl(1'b0, 1'b0, TM_AUTO, 1'b0, 1'b1);
    wt_idx(16'h2, 20);
    wt_sig(0, 20);
    wt_idx(16'h3, 100);
    repeat (30) @(negedge pclk);
    chk(step_index === 16'h3, "dwell held");
    wt_idx(16'h5, 200);
    wt_idx(16'h2, 100);
    wctrl(1'b0, 1'b0, TM_AUTO, 1'b1, 1'b1);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(!(rd[0] === 1'b1 && rd[1] === 1'b1), "list and sweep both on");
    wctrl(1'b0, 1'b0, TM_AUTO, 1'b0, 1'b0);
    wt_sig(1, 20);
    $display("test auto done");
  endtask : t_auto

  task t_single;
    wctrl(1'b0, 1'b0, TM_SINGLE, 1'b0, 1'b1);
    wt_idx(16'h2, 20);
    repeat (100) @(negedge pclk);
    chk(step_index === 16'h2, "single waits");
    cmd(CMD_EXEC);
    wt_idx(16'h5, 300);
    repeat (100) @(negedge pclk);
    chk(step_index === 16'h5, "single holds end");
    cmd(CMD_EXEC);
    wt_idx(16'h3, 300);
    cmd(CMD_RESET);
    wt_idx(16'h2, 20);
    wctrl(1'b1, 1'b1, TM_SINGLE, 1'b0, 1'b1);
    @(posedge pclk) fire <= 1'b1;
    @(posedge pclk) fire <= 1'b0;
    wt_idx(16'h3, 200);
    wt_idx(16'h5, 300);
    wt_idx(16'h2, 60);
    repeat (100) @(negedge pclk);
    chk(step_index === 16'h2, "one cycle per pulse");
    wctrl(1'b0, 1'b0, TM_SINGLE, 1'b0, 1'b0);
    $display("test single done");
  endtask : t_single

  task t_step;
    int k;
    int s0;
    wctrl(1'b0, 1'b0, TM_STEP, 1'b0, 1'b1);
    wt_idx(16'h2, 20);
    repeat (2) @(negedge pclk);
    s0 = strobes;
    cmd(CMD_DOWN);
    repeat (60) @(negedge pclk);
    chk(step_index === 16'h2, "down below start");
    chk(strobes == s0, "strobe on ignored step");
    for (k = 3; k <= 5; k++) begin
      cmd(CMD_UP);
      wt_idx(16'(k), 60);
    end
    cmd(CMD_DOWN);
    wt_idx(16'h4, 60);
    cmd(CMD_UP);
    wt_idx(16'h5, 60);
    cmd(CMD_UP);
    repeat (20) @(negedge pclk);
    chk(step_index === 16'h5, "up past end");
    cmd(CMD_EXEC);
    wt_idx(16'h2, 60);
    repeat (2) @(negedge pclk);
    chk(strobes == s0 + 6, "one strobe per step");
    $display("test step done");
  endtask : t_step

  task t_overrun;
    int k;
    wctrl(1'b0, 1'b0, TM_STEP, 1'b0, 1'b0);
    apb(1'b1, OFS_START, 32'h0);
    apb(1'b1, OFS_STOP, 32'hf);
    wctrl(1'b0, 1'b0, TM_STEP, 1'b0, 1'b1);
    wt_idx(16'h0, 40);
    for (k = 0; k < 3; k++) cmd(CMD_EXEC);
    wt_idx(16'h3, 200);
    for (k = 0; k < 10; k++) cmd(CMD_EXEC);
    wt_sig(2, 200);
    wt_sig(3, 400);
    wt_sig(1, 50);
    apb(1'b1, OFS_STATUS, 32'h1 << ST_OVR);
    @(negedge pclk);
    chk(overrun === 1'b0 && gen_error === 1'b1, "overrun clear");
    $display("test overrun done");
  endtask : t_overrun

  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_auto();
    t_single();
    t_step();
    t_overrun();
    tally_and_finish();
  end
endmodule : sweep_list_trigger_sequencer_tb
